// File: inc/abs_coproc_defs.vh
// Constants for the absolute sum and difference coprocessor block.
`ifndef ABS_COPROC_DEFS_VH
`define ABS_COPROC_DEFS_VH
// Register byte offsets on the Avalon-MM slave.
`define OFS_INSTR   8'h00
`define OFS_OPERAND 8'h04
`define OFS_STATUS  8'h08
`define OFS_RES_LO  8'h0C
`define OFS_RES_HI  8'h10
`define OFS_REG_SEL 8'h14
`define OFS_REG_LO  8'h18
`define OFS_REG_HI  8'h1C
// Instruction word field positions.
`define F_SEL_HI 31
`define F_SEL_LO 29
`define F_S1_HI  28
`define F_S1_LO  25
`define F_S2_HI  24
`define F_S2_LO  21
`define F_D_HI   20
`define F_D_LO   16
// Operation code patterns.
`define OP_SUM_SHORT 8'h09
`define OP_SUM_HOST  16'h4900
`define OP_SUM_MEM   8'h89
`define OP_DIF_SHORT 8'h17
`define OP_DIF_HOST  16'h5600
`define OP_DIF_MEM   5'h13
// Destination code of the accumulator; bit 4 of a code picks file b.
`define ACC_CODE    5'h1F
`define DEST_FILE_B 4
// Status bit positions.
`define ST_BUSY    0
`define ST_WAIT    1
`define ST_ILLEGAL 2
`define ST_STRAY   3
// Reset values.
`define RST_WORD 32'h0000_0000
`define RST_DATA 64'h0000_0000_0000_0000
`define RST_SEL  5'h00
// Biased exponent ceilings that mean overflow.
`define EXP_MAX_S 12'h0FF
`define EXP_MAX_D 12'h7FF
`endif

// File: rtl/abs_sum_diff_coproc_ops.v
// Decoder and executor for the absolute sum and absolute difference operations.
`timescale 1ns/1ps
`default_nettype none
`include "abs_coproc_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Short form: magnitude of source sum to destination.
// - Sum sources come from opposite register files.
// - Only floating precisions decode; integer forms rejected.
// - Word fields: select, sources, destination, opcode.
// - Host form loads both sources then sums.
// - Host sum form is single precision only.
// - Memory sum forms use their own opcode.
// - Short difference: first magnitude minus second magnitude.
// - Difference: first from file a, second file b.
// - Host difference form loads sources then subtracts.
// - Host difference form is single precision only.
// - Destination may name the accumulator.
// - Memory difference forms use their own opcode.
module abs_sum_diff_coproc_ops
#(
    parameter [2:0] SELECT_CODE = 3'h0,
    parameter       FILE_DEPTH  = 10
)
(
    // Clock and reset.
    input  wire        clk_i,
    input  wire        resetn_i,
    // Avalon-MM slave.
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Block status.
    output wire        busy_o
);

////////////////////////////////////////////////////////////////////////////////
localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_LOAD = 3'b010;
localparam [2:0] S_EXEC = 3'b100;
localparam [4:0] DEPTH5 = FILE_DEPTH[4:0];

// Machine state and the latched instruction.
reg [2:0]  state;
reg [3:0]  first_source_field;
reg [3:0]  second_source_field;
reg [4:0]  destination_field;
reg        op_diff;
reg        op_dbl;
reg [2:0]  words_needed;
reg [2:0]  word_cnt;

// Register files, accumulator and software-visible state.
reg [63:0] file_a [0:FILE_DEPTH-1];
reg [63:0] file_b [0:FILE_DEPTH-1];
reg [63:0] acc;
reg [63:0] last_result;
reg [4:0]  reg_sel;
reg        illegal;
reg        stray;
reg        rd_ready;
integer    n;

////////////////////////////////////////////////////////////////////////////////
// Decodes an operation code into {valid, diff, dbl, words}.
function [5:0] decode_op;
    input [15:0] op;
    begin
        decode_op = 6'h00;
        if (op[15:8] == `OP_SUM_SHORT && op[6:0] == 7'h00)
            decode_op = {2'b10, op[7], 3'h0};
        else if (op == `OP_SUM_HOST)
            decode_op = {3'b100, 3'h2};
        else if (op[15:8] == `OP_SUM_MEM && op[6:0] == 7'h00)
            decode_op = {2'b10, op[7], op[7] ? 3'h4 : 3'h2};
        else if (op[15:8] == `OP_DIF_SHORT && op[6:0] == 7'h00)
            decode_op = {2'b11, op[7], 3'h0};
        else if (op == `OP_DIF_HOST)
            decode_op = {3'b110, 3'h2};
        else if (op[15:11] == `OP_DIF_MEM && op[9:0] == 10'h000)
            decode_op = {2'b11, op[10], op[10] ? 3'h4 : 3'h2};
    end
endfunction

// Merges a written word into an old one under the byte enables.
function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer      k;
    begin
        for (k = 0; k < 4; k = k + 1)
            be_merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
    end
endfunction

// Tells whether a destination code names an existing register.
function dest_ok;
    input [4:0] code;
    begin
        dest_ok = (code == `ACC_CODE) || ({1'b0, code[3:0]} < DEPTH5);
    end
endfunction

// Adds, or subtracts magnitudes; truncates, flushes denormals and underflow to zero.
function [63:0] fp_addsub;
    input [63:0] a;
    input [63:0] b;
    input        dif;
    input        dbl;
    reg   [11:0] ea;
    reg   [11:0] eb;
    reg   [11:0] el;
    reg   [11:0] er;
    reg   [11:0] sh;
    reg   [54:0] ma;
    reg   [54:0] mb;
    reg   [54:0] ml;
    reg   [54:0] ms;
    reg   [54:0] mr;
    reg          sa;
    reg          sb;
    reg          sl;
    reg          ss;
    reg          sr;
    reg          swp;
    integer      i;
    begin
        ea = dbl ? {1'b0, a[62:52]} : {4'h0, a[30:23]};
        eb = dbl ? {1'b0, b[62:52]} : {4'h0, b[30:23]};
        ma = (ea == 12'h000) ? 55'h0 :
             dbl ? {2'b01, a[51:0], 1'b0} : {2'b01, a[22:0], 30'h0};
        mb = (eb == 12'h000) ? 55'h0 :
             dbl ? {2'b01, b[51:0], 1'b0} : {2'b01, b[22:0], 30'h0};
        sa = dif ? 1'b0 : (dbl ? a[63] : a[31]);
        sb = dif ? 1'b1 : (dbl ? b[63] : b[31]);
        swp = {eb, mb} > {ea, ma};
        el = swp ? eb : ea;
        ml = swp ? mb : ma;
        sl = swp ? sb : sa;
        ms = swp ? ma : mb;
        ss = swp ? sa : sb;
        sh = el - (swp ? ea : eb);
        ms = (sh > 12'h036) ? 55'h0 : ms >> sh;
        mr = (sl == ss) ? ml + ms : ml - ms;
        er = el;
        if (mr[54])
        begin
            mr = mr >> 1;
            er = er + 12'h001;
        end
        for (i = 0; i < 54; i = i + 1)
            if (!mr[53] && mr != 55'h0 && er > 12'h001)
            begin
                mr = mr << 1;
                er = er - 12'h001;
            end
        // The sum's sign is dropped, which yields its magnitude.
        sr = dif & sl & (mr != 55'h0);
        if (!mr[53])
            fp_addsub = `RST_DATA;
        else if (dbl)
            fp_addsub = (er >= `EXP_MAX_D) ? {sr, 11'h7FF, 52'h0} :
                        {sr, er[10:0], mr[52:1]};
        else
            fp_addsub = (er >= `EXP_MAX_S) ? {32'h0, sr, 8'hFF, 23'h0} :
                        {32'h0, sr, er[7:0], mr[52:30]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus decode and the requests that must wait for the machine.
wire idle      = (state == S_IDLE);
wire wr_instr  = avs_write_i && (avs_address_i == `OFS_INSTR);
wire wr_oper   = avs_write_i && (avs_address_i == `OFS_OPERAND);
wire wr_stat   = avs_write_i && (avs_address_i == `OFS_STATUS);
wire wr_sel    = avs_write_i && (avs_address_i == `OFS_REG_SEL);
wire wr_lo     = avs_write_i && (avs_address_i == `OFS_REG_LO);
wire wr_hi     = avs_write_i && (avs_address_i == `OFS_REG_HI);
wire hold_wr   = !idle && (wr_instr || wr_lo || wr_hi);
wire hold_rd   = avs_read_i && !rd_ready;

assign avs_waitrequest_o = hold_wr || hold_rd;
assign busy_o            = !idle;

// Fields of an incoming instruction word.
wire [31:0] wd   = avs_writedata_i;
wire [2:0]  f_sel = wd[`F_SEL_HI:`F_SEL_LO];
wire [3:0]  f_s1 = wd[`F_S1_HI:`F_S1_LO];
wire [3:0]  f_s2 = wd[`F_S2_HI:`F_S2_LO];
wire [4:0]  f_d  = wd[`F_D_HI:`F_D_LO];
wire [5:0]  dec  = decode_op(wd[15:0]);
wire        srcs_ok = ({1'b0, f_s1} < DEPTH5) && ({1'b0, f_s2} < DEPTH5);
wire        go   = wr_instr && idle && (f_sel == SELECT_CODE);
wire        bad  = go && !(dec[5] && srcs_ok && dest_ok(f_d));
wire        take_oper = wr_oper && (state == S_LOAD);

// Operand routing: singles fill source one then two; doubles a lo, a hi, b lo, b hi.
wire        to_b  = op_dbl ? word_cnt[1] : word_cnt[0];
wire        to_hi = op_dbl & word_cnt[0];

// Result of the latched operation, first source file a, second file b.
wire [63:0] exec_val = fp_addsub(file_a[first_source_field],
                                 file_b[second_source_field],
                                 op_diff, op_dbl);

// Byte-enable merges for the software window onto the registers.
wire [63:0] sel_val = (reg_sel == `ACC_CODE) ? acc :
                      reg_sel[`DEST_FILE_B] ? file_b[reg_sel[3:0]] :
                      file_a[reg_sel[3:0]];
wire [31:0] sel_new = be_merge({27'h0, reg_sel}, wd, avs_byteenable_i);
wire [31:0] lo_new  = be_merge(sel_val[31:0], wd, avs_byteenable_i);
wire [31:0] hi_new  = be_merge(sel_val[63:32], wd, avs_byteenable_i);

////////////////////////////////////////////////////////////////////////////////
// Instruction sequencing, operand loading and result write-back.
always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        state               <= S_IDLE;
        first_source_field  <= 4'h0;
        second_source_field <= 4'h0;
        destination_field   <= 5'h00;
        op_diff             <= 1'b0;
        op_dbl              <= 1'b0;
        words_needed        <= 3'h0;
        word_cnt            <= 3'h0;
        acc                 <= `RST_DATA;
        last_result         <= `RST_DATA;
        for (n = 0; n < FILE_DEPTH; n = n + 1)
        begin
            file_a[n] <= `RST_DATA;
            file_b[n] <= `RST_DATA;
        end
    end
    else
    begin
        case (state)
            S_IDLE:
            begin
                if (go && !bad)
                begin
                    first_source_field  <= f_s1;
                    second_source_field <= f_s2;
                    destination_field   <= f_d;
                    op_diff             <= dec[4];
                    op_dbl              <= dec[3];
                    words_needed        <= dec[2:0];
                    word_cnt            <= 3'h0;
                    state <= (dec[2:0] == 3'h0) ? S_EXEC : S_LOAD;
                end
                else if (wr_lo && dest_ok(reg_sel))
                begin
                    if (reg_sel == `ACC_CODE)
                        acc[31:0] <= lo_new;
                    else if (reg_sel[`DEST_FILE_B])
                        file_b[reg_sel[3:0]][31:0] <= lo_new;
                    else
                        file_a[reg_sel[3:0]][31:0] <= lo_new;
                end
                else if (wr_hi && dest_ok(reg_sel))
                begin
                    if (reg_sel == `ACC_CODE)
                        acc[63:32] <= hi_new;
                    else if (reg_sel[`DEST_FILE_B])
                        file_b[reg_sel[3:0]][63:32] <= hi_new;
                    else
                        file_a[reg_sel[3:0]][63:32] <= hi_new;
                end
            end
            S_LOAD:
            begin
                if (take_oper)
                begin
                    // A single word lands as a 32-bit value with a clear top.
                    if (to_hi && to_b)
                        file_b[second_source_field][63:32] <= wd;
                    else if (to_hi)
                        file_a[first_source_field][63:32] <= wd;
                    else if (to_b)
                        file_b[second_source_field] <= {32'h0, wd};
                    else
                        file_a[first_source_field] <= {32'h0, wd};
                    word_cnt <= word_cnt + 3'h1;
                    if (word_cnt == words_needed - 3'h1)
                        state <= S_EXEC;
                end
            end
            S_EXEC:
            begin
                last_result <= exec_val;
                if (destination_field == `ACC_CODE)
                    acc <= exec_val;
                else if (destination_field[`DEST_FILE_B])
                    file_b[destination_field[3:0]] <= exec_val;
                else
                    file_a[destination_field[3:0]] <= exec_val;
                state <= S_IDLE;
            end
            default:
                state <= S_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sticky error flags, cleared by writing one; a new event wins.
always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        illegal <= 1'b0;
        stray   <= 1'b0;
        reg_sel <= `RST_SEL;
    end
    else
    begin
        illegal <= bad || (illegal && !(wr_stat && wd[`ST_ILLEGAL]));
        stray   <= (wr_oper && state != S_LOAD) ||
                   (stray && !(wr_stat && wd[`ST_STRAY]));
        if (wr_sel)
            reg_sel <= sel_new[4:0];
    end
end

// Reads take one wait cycle so the data comes from a flip-flop.
always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        rd_ready       <= 1'b0;
        avs_readdata_o <= `RST_WORD;
    end
    else
    begin
        rd_ready <= hold_rd;
        if (hold_rd)
        begin
            if (avs_address_i == `OFS_STATUS)
                avs_readdata_o <= {28'h0, stray, illegal,
                                   state == S_LOAD, !idle};
            else if (avs_address_i == `OFS_RES_LO)
                avs_readdata_o <= last_result[31:0];
            else if (avs_address_i == `OFS_RES_HI)
                avs_readdata_o <= last_result[63:32];
            else if (avs_address_i == `OFS_REG_SEL)
                avs_readdata_o <= {27'h0, reg_sel};
            else if (avs_address_i == `OFS_REG_LO)
                avs_readdata_o <= sel_val[31:0];
            else if (avs_address_i == `OFS_REG_HI)
                avs_readdata_o <= sel_val[63:32];
            else
                avs_readdata_o <= `RST_WORD;
        end
    end
end

endmodule // abs_sum_diff_coproc_ops
`default_nettype wire

// File: verification/abs_ops_properties.sv
// Concurrent checks on the ports of the absolute sum and difference block.
`timescale 1ns/1ps
`default_nettype none
`include "abs_coproc_defs.vh"
module abs_ops_properties
#(
    parameter [2:0] SELECT_CODE = 3'h0,
    parameter       FILE_DEPTH  = 10
)
(
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // Avalon-MM slave.
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // Status.
    input wire logic        busy_o
);
    // An accepted instruction write, and whether it addresses this block with sane fields.
    wire logic [15:0] op   = avs_writedata_i[15:0];
    wire logic        take = avs_write_i && !avs_waitrequest_o && avs_address_i == `OFS_INSTR;
    wire logic        mine = take && avs_writedata_i[31:29] == SELECT_CODE
        && avs_writedata_i[28:25] < FILE_DEPTH && avs_writedata_i[24:21] < FILE_DEPTH
        && (avs_writedata_i[19:16] < FILE_DEPTH || avs_writedata_i[20:16] == `ACC_CODE);
    wire logic        legal = op inside {16'h0900, 16'h0980, 16'h4900, 16'h8900, 16'h8980,
        16'h1700, 16'h1780, 16'h5600, 16'h9800, 16'h9C00};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////////
    chk_read_one_wait: assert property (
        $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read did not take exactly one wait cycle");
    chk_instr_reads_zero: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i == `OFS_INSTR
        |-> avs_readdata_o == 32'h0000_0000) else $error("instruction port read not zero");
    chk_short_done: assert property (
        mine && (op == 16'h0900 || op == 16'h0980 || op == 16'h1700 || op == 16'h1780)
        |=> ##[0:1] !busy_o) else $error("short form kept the block busy");
    chk_host_waits: assert property (
        mine && (op == 16'h4900 || op == 16'h5600) |=> busy_o[*3])
        else $error("host form finished before its operands");
    chk_mem_double_waits: assert property (
        mine && (op == 16'h8980 || op == 16'h9C00) |=> busy_o[*5])
        else $error("double memory form finished before four words");
    chk_bad_op_idle: assert property (
        mine && !legal |=> !busy_o) else $error("unsupported encoding started work");
    chk_foreign_ignored: assert property (
        take && avs_writedata_i[31:29] != SELECT_CODE |=> !busy_o)
        else $error("word for another coprocessor started work");
    chk_instr_stall: assert property (
        avs_write_i && busy_o && avs_address_i == `OFS_INSTR |-> avs_waitrequest_o)
        else $error("instruction accepted while busy");
    chk_operand_no_wait: assert property (
        avs_write_i && avs_address_i == `OFS_OPERAND |-> !avs_waitrequest_o)
        else $error("operand write was stalled");
endmodule // abs_ops_properties

bind abs_sum_diff_coproc_ops abs_ops_properties #(
    .SELECT_CODE(SELECT_CODE), .FILE_DEPTH(FILE_DEPTH)) i_abs_ops_properties (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));
`default_nettype wire

// File: verification/host_issuer.sv
// Host model that issues coprocessor instructions and operands over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "abs_coproc_defs.vh"
module host_issuer
(
    // Clock.
    input  wire logic        clk_i,
    // Avalon-MM master.
    output var  logic [7:0]  address_o,
    output var  logic        read_o,
    output var  logic        write_o,
    output var  logic [31:0] writedata_o,
    input  wire logic        waitrequest_i
);
    // Word memory for the memory forms, and the host address register.
    logic [31:0] mem [0:15];
    logic [31:0] rs;

    // Idle bus at time zero.
    initial
    begin
        address_o = 8'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0000_0000;
    end

    // One write, held until the slave stops waiting.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        address_o <= a;
        writedata_o <= d;
        write_o <= 1'b1;
        do @(posedge clk_i); while (waitrequest_i !== 1'b0);
        write_o <= 1'b0;
    endtask

    // One read, held until the slave stops waiting.
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        address_o <= a;
        read_o <= 1'b1;
        do @(posedge clk_i); while (waitrequest_i !== 1'b0);
        read_o <= 1'b0;
    endtask

    // Register transfer form: two single words from host registers.
    task automatic host2(input logic [31:0] ins, input logic [31:0] w0, input logic [31:0] w1);
        wr(`OFS_INSTR, ins);
        wr(`OFS_OPERAND, w0);
        wr(`OFS_OPERAND, w1);
    endtask

    // Memory transfer form, stepping the address by one word either way.
    task automatic memx(input logic [31:0] ins, input logic [31:0] base, input int n,
                        input bit pre);
        rs = base;
        wr(`OFS_INSTR, ins);
        repeat (n)
        begin
            if (pre) rs = rs - 32'd32;
            wr(`OFS_OPERAND, mem[rs[8:5]]);
            if (!pre) rs = rs + 32'd32;
        end
    endtask
endmodule // host_issuer
`default_nettype wire

// File: verification/abs_sum_diff_coproc_ops_test.sv
// Self-checking bench for the absolute sum and difference block.
`timescale 1ns/1ps
`default_nettype none
`include "abs_coproc_defs.vh"
module abs_sum_diff_coproc_ops_test;
    localparam [2:0] SEL = 3'h0;
    localparam int   FD  = 10;
    logic        clk_i, resetn_i, read, write, wrq, busy;
    logic [7:0]  address;
    logic [31:0] writedata, readdata;
    logic [31:0] q[$];
    int          mismatches = 0, check_count = 0, cycles = 0, i;

    abs_sum_diff_coproc_ops #(.SELECT_CODE(SEL), .FILE_DEPTH(FD)) i_abs_sum_diff_coproc_ops (
        .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(address), .avs_read_i(read),
        .avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(readdata), .avs_waitrequest_o(wrq), .busy_o(busy));
    host_issuer i_host_issuer (.clk_i(clk_i), .address_o(address), .read_o(read),
        .write_o(write), .writedata_o(writedata), .waitrequest_i(wrq));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 250 MHz.
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("wrong value at %0t: read %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compares every accepted read with the oldest expectation.
    always @(posedge clk_i)
        if (resetn_i === 1'b1 && read === 1'b1 && wrq === 1'b0)
            check(readdata, q.pop_front());

    // Cuts a hung run short.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        i_host_issuer.rd(a);
    endtask

    // Whole numbers as float bits; single is narrowed from the double pattern.
    function automatic logic [63:0] fbits(input int v, input bit dbl);
        logic [63:0] d;
        d = $realtobits(real'(v));
        if (dbl || v == 0)
            fbits = d;
        else
            fbits = {32'h0, d[63], 8'(d[62:52] - 11'h380), d[51:29]};
    endfunction

    // Loads a register through the window.
    task automatic load(input logic [4:0] code, input logic [63:0] v);
        i_host_issuer.wr(`OFS_REG_SEL, {27'h0, code});
        i_host_issuer.wr(`OFS_REG_LO, v[31:0]);
        i_host_issuer.wr(`OFS_REG_HI, v[63:32]);
    endtask

    // Runs one form on random whole values and reads the result back.
    task automatic run_op(input int k, input bit pre);
        logic [15:0] ops [10] = '{16'h0900, 16'h0980, 16'h4900, 16'h8900, 16'h8980,
                                  16'h1700, 16'h1780, 16'h5600, 16'h9800, 16'h9C00};
        int          kind [10] = '{0, 0, 1, 2, 2, 0, 0, 1, 2, 2};
        bit          dbls [10] = '{0, 1, 0, 0, 1, 0, 1, 0, 0, 1};
        logic [3:0]  s1, s2;
        logic [4:0]  d;
        logic [31:0] ins;
        logic [63:0] wa, wb, r;
        logic [31:0] w [4];
        int          a, b, x, n;
        a = int'($urandom_range(200)) - 100;
        b = int'($urandom_range(200)) - 100;
        x = k >= 5 ? (a < 0 ? -a : a) - (b < 0 ? -b : b) : (a + b < 0 ? -(a + b) : a + b);
        wa = fbits(a, dbls[k]);
        wb = fbits(b, dbls[k]);
        r = fbits(x, dbls[k]);
        s1 = 4'($urandom_range(FD - 1));
        s2 = 4'($urandom_range(FD - 1));
        d = k % 3 == 0 ? `ACC_CODE : {k[0], 4'($urandom_range(FD - 1))};
        ins = {SEL, s1, s2, d, ops[k]};
        if (kind[k] == 0)
        begin
            load({1'b0, s1}, wa);
            load({1'b1, s2}, wb);
            i_host_issuer.wr(`OFS_INSTR, ins);
        end
        else if (kind[k] == 1)
            i_host_issuer.host2(ins, wa[31:0], wb[31:0]);
        else
        begin
            w = '{wa[31:0], dbls[k] ? wa[63:32] : wb[31:0], wb[31:0], wb[63:32]};
            n = dbls[k] ? 4 : 2;
            for (int j = 0; j < n; j++)
                i_host_issuer.mem[pre ? 7 - j : 8 + j] = w[j];
            i_host_issuer.memx(ins, 32'd256, n, pre);
        end
        // A word for another coprocessor waits for idle and is then ignored.
        i_host_issuer.wr(`OFS_INSTR, {SEL + 3'h1, 13'h0, 16'h0900});
        i_host_issuer.wr(`OFS_REG_SEL, {27'h0, d});
        rd(`OFS_REG_LO, r[31:0]);
        rd(`OFS_REG_HI, r[63:32]);
        rd(`OFS_RES_LO, r[31:0]);
        rd(`OFS_RES_HI, r[63:32]);
        $display("test form %0d pre %0d done", k, pre);
    endtask

    // Main sequence.
    initial
    begin
        static logic [31:0] bad [4] = '{32'h0000_4980, 32'h0000_5680, 32'h0000_0100,
                                        32'h000F_0900};
        resetn_i = 1'b0;
        void'($urandom(32'hae62a8ce));
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_REG_SEL, 32'h0);
        rd(`OFS_REG_LO, 32'h0);
        rd(`OFS_INSTR, 32'h0);
        rd(8'h20, 32'h0);
        $display("test reset done");
        for (i = 0; i < 20; i++)
            run_op(i % 10, i >= 10);
        foreach (bad[j])
        begin
            i_host_issuer.wr(`OFS_INSTR, {SEL, bad[j][28:0]});
            rd(`OFS_STATUS, 32'h4);
            i_host_issuer.wr(`OFS_STATUS, 32'h4);
        end
        i_host_issuer.wr(`OFS_OPERAND, 32'h1);
        rd(`OFS_STATUS, 32'h8);
        i_host_issuer.wr(`OFS_STATUS, 32'h8);
        rd(`OFS_STATUS, 32'h0);
        $display("test refusals done");
        repeat (4) @(posedge clk_i);
        conclude();
    end
endmodule // abs_sum_diff_coproc_ops_test
`default_nettype wire
